// ---- pwm_defines.svh ----
// Constants for the two-channel pulse generator: register offsets, field
// positions, reset values and counter limits.
// Assumes inclusion by bare name from the package and the modules.
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH

// ****************************************
// Register offsets (byte addresses on the register port)
// ****************************************
`define OFS_CHAN0_DIVIDER_ENABLE 8'h4b
`define OFS_CHAN1_DIVIDER_ENABLE 8'h4c
`define OFS_CHAN0_HIGH_TIME 8'h4e
`define OFS_CHAN1_HIGH_TIME 8'h4f

// ****************************************
// Field positions and reset values
// ****************************************
`define DIV_ENABLE_BIT 7
`define DIV_PRESCALE_MSB 6
`define DIVIDER_RESET 8'h00
`define HIGH_TIME_RESET 8'h00
`define READ_IDLE 8'h00

// ****************************************
// Counter limits
// ****************************************
`define PRESCALE_ZERO 7'h00
`define PRESCALE_ONE 7'h01
`define DUTY_ZERO 8'h00
`define DUTY_ONE 8'h01
`define DUTY_LAST 8'hff

`endif

// ---- pwm_pkg.sv ----
// Types shared by the pulse generator top and its channel module.
// Assumes pwm_defines.svh is on the include path.
package pwm_pkg;
	`include "pwm_defines.svh"

	// ****************************************
	// Channel settings as held in the registers
	// ****************************************
	typedef struct packed {
		logic enable;          // Channel running
		logic [6:0] prescale;  // Divider field
		logic [7:0] high_time; // Duty field
	} chan_cfg_t;

	// Pin drive for one pulse output
	typedef struct packed {
		logic out;    // Level to drive
		logic oe_n;   // Low while driving
	} pin_drive_t;

	// Channel phase
	typedef enum logic [1:0] {
		CH_IDLE = 2'b01,
		CH_RUN = 2'b10
	} chan_state_t;
endpackage

// ---- pwm_channel.sv ----
// One pulse-width channel: prescaler, 8-bit duty counter, compare.
// Assumes settings come from registers on the same clock.
`timescale 1ns/10ps
`include "pwm_defines.svh"

module pwm_channel
	import pwm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input chan_cfg_t cfg,
	output logic level
);
	// ****************************************
	// State
	// ****************************************
	chan_state_t state_q, state_d;      // Idle or running
	logic [6:0] pre_q, pre_d;           // Prescale counter
	logic [7:0] duty_q, duty_d;         // Duty counter
	logic level_q, level_d;             // Registered output level
	logic tick;                         // One divided-clock step

	// Divided clock step when prescaler hits the field
	assign tick = (pre_q == cfg.prescale);

	// Next-state computation
	always_comb begin
		state_d = state_q;
		pre_d = pre_q;
		duty_d = duty_q;
		level_d = 1'b0;
		case (state_q)
			CH_IDLE: begin
				// Counters held at zero, output low
				pre_d = `PRESCALE_ZERO;
				duty_d = `DUTY_ZERO;
				if (cfg.enable) begin
					state_d = CH_RUN;
				end
			end
			CH_RUN: begin
				if (!cfg.enable) begin
					state_d = CH_IDLE;
					pre_d = `PRESCALE_ZERO;
					duty_d = `DUTY_ZERO;
				end else begin
					// Count up, back to zero after the field value
					pre_d = tick ? `PRESCALE_ZERO : pre_q + `PRESCALE_ONE;
					if (tick) begin
						// Wraps FF to 00, period of 256 steps
						duty_d = duty_q + `DUTY_ONE;
					end
					// Compare with live duty field, FF forces high
					level_d = (cfg.high_time == `DUTY_LAST) || (duty_q < cfg.high_time);
				end
			end
			default: begin
				state_d = CH_IDLE;
				pre_d = `PRESCALE_ZERO;
				duty_d = `DUTY_ZERO;
			end
		endcase
	end

	// Register stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= CH_IDLE;
			pre_q <= `PRESCALE_ZERO;
			duty_q <= `DUTY_ZERO;
			level_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pre_q <= pre_d;
			duty_q <= duty_d;
			level_q <= level_d;
		end
	end

	assign level = level_q;
endmodule

// ---- pwm_generator.sv ----
// Two-channel pulse-width generator with its register bank.
// Assumes clk is the base oscillator clock and the register port is
// driven synchronously by the device's register access logic.
//
// Behaviour
// - Two independent channels, own settings and pin.
// - Divider runs from base oscillator clock.
// - 7-bit prescaler wraps after reaching divider field.
// - Divided clock is base over field plus one.
// - Duty counter steps on divided clock, 256 period.
// - Output high while counter below duty field.
// - Duty field FF keeps output high always.
// - Duty cycle is field over 256 for fields below FF.
// - Divider bit 7 enables; host disables before rewriting.
// - Duty field may change while running.
// - Pins support push-pull or open-drain drive.
`timescale 1ns/10ps
`include "pwm_defines.svh"

module pwm_generator
	import pwm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	input wire logic open_drain_zero,
	input wire logic open_drain_one,
	output logic pulse_out_zero,
	output logic pulse_out_zero_oe_n,
	output logic pulse_out_one,
	output logic pulse_out_one_oe_n
);
	// ****************************************
	// Register bank
	// ****************************************
	logic [7:0] div0_q, div0_d;    // chan0_divider_enable
	logic [7:0] div1_q, div1_d;    // chan1_divider_enable
	logic [7:0] high0_q, high0_d;  // chan0_high_time
	logic [7:0] high1_q, high1_d;  // chan1_high_time
	logic [7:0] rdata_q, rdata_d;  // Read data
	chan_cfg_t cfg [2];            // Per-channel settings
	logic [1:0] level;             // Channel levels
	logic [1:0] open_drain;        // Drive choice per pin
	pin_drive_t drive [2];         // Per-pin drive

	// Write and read decode
	always_comb begin
		div0_d = div0_q;
		div1_d = div1_q;
		high0_d = high0_q;
		high1_d = high1_q;
		rdata_d = rdata_q;
		if (reg_wr) begin
			case (reg_addr)
				`OFS_CHAN0_DIVIDER_ENABLE: div0_d = reg_wdata;
				`OFS_CHAN1_DIVIDER_ENABLE: div1_d = reg_wdata;
				`OFS_CHAN0_HIGH_TIME: high0_d = reg_wdata;
				`OFS_CHAN1_HIGH_TIME: high1_d = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`OFS_CHAN0_DIVIDER_ENABLE: rdata_d = div0_q;
				`OFS_CHAN1_DIVIDER_ENABLE: rdata_d = div1_q;
				`OFS_CHAN0_HIGH_TIME: rdata_d = high0_q;
				`OFS_CHAN1_HIGH_TIME: rdata_d = high1_q;
				default: rdata_d = `READ_IDLE;
			endcase
		end
	end

	// Register storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div0_q <= `DIVIDER_RESET;
			div1_q <= `DIVIDER_RESET;
			high0_q <= `HIGH_TIME_RESET;
			high1_q <= `HIGH_TIME_RESET;
			rdata_q <= `READ_IDLE;
		end else begin
			div0_q <= div0_d;
			div1_q <= div1_d;
			high0_q <= high0_d;
			high1_q <= high1_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	// Combinational address match
	assign reg_hit = (reg_addr == `OFS_CHAN0_DIVIDER_ENABLE) || (reg_addr == `OFS_CHAN1_DIVIDER_ENABLE) ||
		(reg_addr == `OFS_CHAN0_HIGH_TIME) || (reg_addr == `OFS_CHAN1_HIGH_TIME);

	// Settings per channel
	assign cfg[0] = '{enable: div0_q[`DIV_ENABLE_BIT], prescale: div0_q[`DIV_PRESCALE_MSB:0], high_time: high0_q};
	assign cfg[1] = '{enable: div1_q[`DIV_ENABLE_BIT], prescale: div1_q[`DIV_PRESCALE_MSB:0], high_time: high1_q};
	assign open_drain = {open_drain_one, open_drain_zero};

	// ****************************************
	// Channels and pin drive
	// ****************************************
	generate
		for (genvar i = 0; i < 2; i++) begin : g_chan
			// Independent channel on the base clock
			pwm_channel u_chan (
				.clk(clk),
				.rst(rst),
				.cfg(cfg[i]),
				.level(level[i])
			);
			// Open drain releases the pin for high
			assign drive[i].out = open_drain[i] ? 1'b0 : level[i];
			assign drive[i].oe_n = open_drain[i] ? level[i] : 1'b0;
		end
	endgenerate

	assign pulse_out_zero = drive[0].out;
	assign pulse_out_zero_oe_n = drive[0].oe_n;
	assign pulse_out_one = drive[1].out;
	assign pulse_out_one_oe_n = drive[1].oe_n;
endmodule

// ---- pwm_load_model.sv ----
// Load on one pulse pin: resolves the wire level.
// Assumes the active-low enable of the generator and a pull-up.
`timescale 1ns/10ps
module pwm_load_model (
	input wire logic out,
	input wire logic oe_n,
	output logic pin
);
	// Pin taken as an output with its alternate select set by the host
	// Released pin rises through the pull-up
	assign pin = oe_n ? 1'b1 : out;
endmodule

// ---- pwm_generator_assertions.sv ----
// Checker on the generator ports: decode, read port, pin drive.
// Assumes one clock and an async active-high reset.
`timescale 1ns/10ps
module pwm_generator_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_hit,
	input wire logic open_drain_zero,
	input wire logic open_drain_one,
	input wire logic pulse_out_zero,
	input wire logic pulse_out_zero_oe_n,
	input wire logic pulse_out_one,
	input wire logic pulse_out_one_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Pin seen high by the load
	wire logic hi0 = pulse_out_zero | pulse_out_zero_oe_n;
	property p_hit; reg_hit == (reg_addr inside {8'h4b, 8'h4c, 8'h4e, 8'h4f}); endproperty
	a_hit: assert property (p_hit) else $error("decode");
	property p_pp0; !open_drain_zero |-> !pulse_out_zero_oe_n; endproperty
	a_pp0: assert property (p_pp0) else $error("pp0");
	property p_od0; open_drain_zero |-> !pulse_out_zero; endproperty
	a_od0: assert property (p_od0) else $error("od0");
	property p_pp1; !open_drain_one |-> !pulse_out_one_oe_n; endproperty
	a_pp1: assert property (p_pp1) else $error("pp1");
	property p_od1; open_drain_one |-> !pulse_out_one; endproperty
	a_od1: assert property (p_od1) else $error("od1");
	property p_off; reg_wr && reg_addr == 8'h4b && !reg_wdata[7] |-> ##2 !hi0; endproperty
	a_off: assert property (p_off) else $error("off");
	property p_rb; reg_wr && reg_hit ##2 (reg_rd && reg_addr == $past(reg_addr, 2))
		|=> reg_rdata == $past(reg_wdata, 3); endproperty
	a_rb: assert property (p_rb) else $error("readback");
	property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("hold");
endmodule
bind pwm_generator pwm_generator_assertions chk (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
	.open_drain_zero(open_drain_zero), .open_drain_one(open_drain_one), .pulse_out_zero(pulse_out_zero),
	.pulse_out_zero_oe_n(pulse_out_zero_oe_n), .pulse_out_one(pulse_out_one),
	.pulse_out_one_oe_n(pulse_out_one_oe_n));

// ---- pwm_generator_tb_top.sv ----
// Bench for the two-channel pulse generator: registers, period, duty.
// Assumes the load model and the bound checker are compiled too.
`timescale 1ns/10ps
`include "pwm_defines.svh"
module pwm_generator_tb_top;
	logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, od0 = 0, od1 = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic reg_hit, p0, p0_oe_n, p1, p1_oe_n, pin0, pin1;
	logic [31:0] r, h0, h1;
	int err_total = 0, num_checks = 0, seed = 40;
	always #5 clk = ~clk;
	pwm_generator DUT (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .open_drain_zero(od0),
		.open_drain_one(od1), .pulse_out_zero(p0), .pulse_out_zero_oe_n(p0_oe_n), .pulse_out_one(p1),
		.pulse_out_one_oe_n(p1_oe_n));
	pwm_load_model load0 (.out(p0), .oe_n(p0_oe_n), .pin(pin0));
	pwm_load_model load1 (.out(p1), .oe_n(p1_oe_n), .pin(pin1));
	// High clocks in one period; full period when d is FF
	function automatic logic [31:0] exp_hi(input logic [6:0] n, input logic [7:0] d);
		logic [31:0] p;
		p = {25'h0, n} + 32'h1;
		return (d == 8'hff) ? p << 8 : {24'h0, d} * p;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 num_checks++;
		if (reg_rdata !== e) begin
			err_total++;
			$display("[FAIL] reg %h expected %h seen %h", a, e, reg_rdata);
		end
	endtask
	task automatic chk_cnt(input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] high count expected %0d seen %0d", e, g);
		end
	endtask
	// Count high cycles of a resolved pin
	task automatic cnt(input logic ch, input logic [31:0] len, output logic [31:0] h);
		h = 0;
		repeat (len) begin
			@(negedge clk);
			if ((ch ? pin1 : pin0) === 1'b1) h++;
		end
	endtask
	task automatic run_case(input logic [6:0] a0, input logic [7:0] b0, input logic [6:0] a1, input logic [7:0] b1);
		wr(`OFS_CHAN0_DIVIDER_ENABLE, {1'b0, a0});
		wr(`OFS_CHAN1_DIVIDER_ENABLE, {1'b0, a1});
		wr(`OFS_CHAN0_HIGH_TIME, b0);
		wr(`OFS_CHAN1_HIGH_TIME, b1);
		chk_reg(`OFS_CHAN1_HIGH_TIME, b1);
		wr(`OFS_CHAN0_DIVIDER_ENABLE, {1'b1, a0});
		wr(`OFS_CHAN1_DIVIDER_ENABLE, {1'b1, a1});
		fork
			cnt(1'b0, exp_hi(a0, 8'hff), h0);
			begin
				// Channel one was enabled two clocks after channel zero
				repeat (2) @(posedge clk);
				cnt(1'b1, exp_hi(a1, 8'hff), h1);
			end
		join
		chk_cnt(exp_hi(a0, b0), h0);
		chk_cnt(exp_hi(a1, b1), h1);
		wr(`OFS_CHAN0_HIGH_TIME, ~b0);
		repeat (2) @(posedge clk);
		cnt(1'b0, exp_hi(a0, 8'hff), h0);
		chk_cnt(exp_hi(a0, ~b0), h0);
		wr(`OFS_CHAN0_DIVIDER_ENABLE, {1'b0, a0});
		wr(`OFS_CHAN1_DIVIDER_ENABLE, {1'b0, a1});
		repeat (2) @(posedge clk);
		fork
			cnt(1'b0, 32'd300, h0);
			cnt(1'b1, 32'd300, h1);
		join
		chk_cnt(32'd0, h0);
		chk_cnt(32'd0, h1);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int a = 8'h4b; a < 8'h50; a++) chk_reg(a[7:0], 8'h00);
		wr(8'h4d, 8'h5a);
		chk_reg(8'h4d, 8'h00);
		run_case(7'h00, 8'h00, 7'h01, 8'hff);
		@(posedge clk);
		od0 <= 1'b1;
		od1 <= 1'b1;
		run_case(7'h7f, 8'ha0, 7'h00, 8'h02);
		repeat (3) begin
			r = $random(seed);
			@(posedge clk);
			od0 <= r[4];
			od1 <= r[5];
			run_case({4'h0, r[2:0]}, r[15:8], {4'h0, r[18:16]}, r[31:24]);
		end
		wrap_up;
	end
	initial begin
		repeat (95000) @(posedge clk);
		err_total++;
		wrap_up;
	end
endmodule
